//--- dti_pkg.sv
package dti_pkg;

   // ==========================================================
   // register map, byte addresses
   localparam logic [7:0]  ADDR_CTRL     = 8'h00;
   localparam logic [7:0]  ADDR_FMIN     = 8'h04;
   localparam logic [7:0]  ADDR_FMAX     = 8'h08;
   localparam logic [7:0]  ADDR_FFIX1    = 8'h0C;
   localparam logic [7:0]  ADDR_FFIX2    = 8'h10;
   localparam logic [7:0]  ADDR_FFIX3    = 8'h14;
   localparam logic [7:0]  ADDR_FFIX4    = 8'h18;
   localparam logic [7:0]  ADDR_STATUS   = 8'h1C;
   localparam logic [7:0]  ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0]  ADDR_IRQ_MASK = 8'h24;

   // ==========================================================
   // control register fields
   localparam int          CTRL_CHAN_LSB = 0;
   localparam int          CTRL_MODE_BIT = 4;
   localparam int          CTRL_REF_LSB  = 8;
   localparam int          CTRL_CHAN_W   = 4;
   localparam int          CTRL_REF_W    = 2;

   // ==========================================================
   // status register fields
   localparam int          STAT_RUN_BIT   = 0;
   localparam int          STAT_CCW_BIT   = 1;
   localparam int          STAT_COAST_BIT = 2;
   localparam int          STAT_FAULT_BIT = 3;
   localparam int          STAT_ILOCK_BIT = 4;
   localparam int          STAT_FREQ_LSB  = 16;
   localparam logic [3:0]  CHAN_TERMINAL = 4'h0;

   // ==========================================================
   // frequencies in units of 0.1 Hz
   localparam int          FREQ_W        = 16;
   localparam logic [15:0] FMIN_RST      = 16'h0000;
   localparam logic [15:0] FMAX_RST      = 16'h01F4;
   localparam logic [15:0] FFIX1_RST     = 16'h00C8;
   localparam logic [15:0] FFIX2_RST     = 16'h012C;
   localparam logic [15:0] FFIX3_RST     = 16'h0190;
   localparam logic [15:0] FFIX4_RST     = 16'h01F4;
   localparam int          AREF_W        = 12;

   // ==========================================================
   // timing
   localparam int          CLK_HZ        = 200_000_000;
   localparam int          UPDN_STEP_US  = 1000;
   localparam int          UPDN_STEP_CYC = CLK_HZ / 1_000_000 * UPDN_STEP_US;

   // ==========================================================
   // interrupt events
   localparam int          EV_N          = 4;
   localparam int          EV_FAULT      = 0;
   localparam int          EV_INTERLOCK  = 1;
   localparam int          EV_RUN_START  = 2;
   localparam int          EV_RUN_STOP   = 3;

   // ==========================================================
   // types
   typedef enum logic [0:0] {
      MODE_DIRECTION = 1'b0,
      MODE_START_DIR = 1'b1
   } dti_mode_t;

   typedef enum logic [1:0] {
      REF_ANALOG = 2'b00,
      REF_FIXED  = 2'b01,
      REF_UPDOWN = 2'b10
   } dti_ref_t;

   typedef struct packed {
      logic digital_input_one;
      logic digital_input_two;
      logic digital_input_three;
      logic fixed_freq_one;
      logic fix_sel_bit0;
      logic fix_sel_bit1;
      logic freq_up_input;
      logic freq_down_input;
      logic run_permit_input;
      logic manual_override_input;
   } dti_pins_t;

   localparam int          PINS_W        = $bits(dti_pins_t);

   typedef struct packed {
      logic run;
      logic ccw;
   } dti_fbus_t;

endpackage : dti_pkg

//--- dti_sync.sv
module dti_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   // ==========================================================
   // two flip-flops per bit
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk) begin
            if (!rst_b) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               sync_q <= meta_q;
            end
         end
         assign sync_out[i] = sync_q;
      end
   endgenerate

endmodule : dti_sync

//--- dti_decoder.sv
// Overview of operation
// - direction mode: input one cw, two ccw
// - direction mode: both inputs high switches drive off
// - fixed one select overrides analog reference
// - analog reference scaled between min and max
// - fault input low switches drive off
// - two select bits pick fixed setpoints one-four
// - up/down inputs trim setpoint within limits
// - start mode: input one starts, preset direction
// - start mode: input two high ccw, low cw
// - permit alone never starts the drive
// - permit removed makes the motor coast
// - manual override ignores fieldbus, uses terminals
// - terminal functions act with channel zero or manual override
module dti_decoder #(
   parameter int UPDN_STEP_CYC = dti_pkg::UPDN_STEP_CYC
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         rst_b,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic                              pready,
   output logic [31:0]                       prdata,
   output logic                              pslverr,
   // terminal pins
   input  wire dti_pkg::dti_pins_t           pins,
   // analog reference word, same clock
   input  wire logic [dti_pkg::AREF_W-1:0]   analog_ref,
   // fieldbus command, same clock
   input  wire dti_pkg::dti_fbus_t           fbus_cmd,
   input  wire logic [dti_pkg::FREQ_W-1:0]   fbus_freq,
   // drive command
   output logic                              drive_run,
   output logic                              drive_ccw,
   output logic                              drive_coast,
   output logic [dti_pkg::FREQ_W-1:0]        drive_freq,
   // interrupt
   output logic                              irq
);

   localparam int FW = dti_pkg::FREQ_W;
   localparam int AW = dti_pkg::AREF_W;
   localparam int EN = dti_pkg::EV_N;

   // ==========================================================
   // input sampling
   dti_pkg::dti_pins_t pin_s;

   dti_sync #(
      .W        (dti_pkg::PINS_W)
   ) u_sync (
      .clk      (clk),
      .rst_b    (rst_b),
      .async_in (pins),
      .sync_out (pin_s)
   );

   dti_pkg::dti_pins_t pin_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_q <= '0;
      end else begin
         pin_q <= pin_s;
      end
   end

   // ==========================================================
   // registers
   logic [3:0]     chan_q;
   dti_pkg::dti_mode_t mode_q;
   dti_pkg::dti_ref_t  ref_q;
   logic [FW-1:0]  fmin_q;
   logic [FW-1:0]  fmax_q;
   logic [FW-1:0]  ffix_q [4];
   logic [EN-1:0]  istat_q;
   logic [EN-1:0]  imask_q;
   logic [EN-1:0]  ev;
   logic           fault_q;
   logic           ilock_q;

   logic           acc;
   logic           wr;
   logic           hit;
   logic [31:0]    rd;

   assign acc = psel & penable & ~pready;
   assign wr  = psel & penable & pready & pwrite & ~pslverr;

   always_comb begin
      hit = 1'b1;
      rd  = 32'h0000_0000;
      case (paddr)
         dti_pkg::ADDR_CTRL: begin
            rd[dti_pkg::CTRL_CHAN_LSB +: dti_pkg::CTRL_CHAN_W] = chan_q;
            rd[dti_pkg::CTRL_MODE_BIT]                         = mode_q;
            rd[dti_pkg::CTRL_REF_LSB +: dti_pkg::CTRL_REF_W]   = ref_q;
         end
         dti_pkg::ADDR_FMIN:     rd[FW-1:0] = fmin_q;
         dti_pkg::ADDR_FMAX:     rd[FW-1:0] = fmax_q;
         dti_pkg::ADDR_FFIX1:    rd[FW-1:0] = ffix_q[0];
         dti_pkg::ADDR_FFIX2:    rd[FW-1:0] = ffix_q[1];
         dti_pkg::ADDR_FFIX3:    rd[FW-1:0] = ffix_q[2];
         dti_pkg::ADDR_FFIX4:    rd[FW-1:0] = ffix_q[3];
         dti_pkg::ADDR_STATUS: begin
            rd[dti_pkg::STAT_RUN_BIT]        = drive_run;
            rd[dti_pkg::STAT_CCW_BIT]        = drive_ccw;
            rd[dti_pkg::STAT_COAST_BIT]      = drive_coast;
            rd[dti_pkg::STAT_FAULT_BIT]      = fault_q;
            rd[dti_pkg::STAT_ILOCK_BIT]      = ilock_q;
            rd[dti_pkg::STAT_FREQ_LSB +: FW] = drive_freq;
         end
         dti_pkg::ADDR_IRQ_STAT: rd[EN-1:0] = istat_q;
         dti_pkg::ADDR_IRQ_MASK: rd[EN-1:0] = imask_q;
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // one wait state: answer registered in the first access cycle
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= acc;
         pslverr <= acc & ~hit;
         if (acc && !pwrite) begin
            prdata <= rd;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         chan_q    <= dti_pkg::CHAN_TERMINAL;
         mode_q    <= dti_pkg::MODE_DIRECTION;
         ref_q     <= dti_pkg::REF_ANALOG;
         fmin_q    <= dti_pkg::FMIN_RST;
         fmax_q    <= dti_pkg::FMAX_RST;
         ffix_q[0] <= dti_pkg::FFIX1_RST;
         ffix_q[1] <= dti_pkg::FFIX2_RST;
         ffix_q[2] <= dti_pkg::FFIX3_RST;
         ffix_q[3] <= dti_pkg::FFIX4_RST;
         imask_q   <= '0;
      end else if (wr) begin
         case (paddr)
            dti_pkg::ADDR_CTRL: begin
               chan_q <= pwdata[dti_pkg::CTRL_CHAN_LSB +: dti_pkg::CTRL_CHAN_W];
               mode_q <= dti_pkg::dti_mode_t'(
                            pwdata[dti_pkg::CTRL_MODE_BIT]);
               ref_q  <= dti_pkg::dti_ref_t'(pwdata[dti_pkg::CTRL_REF_LSB
                            +: dti_pkg::CTRL_REF_W]);
            end
            dti_pkg::ADDR_FMIN:     fmin_q    <= pwdata[FW-1:0];
            dti_pkg::ADDR_FMAX:     fmax_q    <= pwdata[FW-1:0];
            dti_pkg::ADDR_FFIX1:    ffix_q[0] <= pwdata[FW-1:0];
            dti_pkg::ADDR_FFIX2:    ffix_q[1] <= pwdata[FW-1:0];
            dti_pkg::ADDR_FFIX3:    ffix_q[2] <= pwdata[FW-1:0];
            dti_pkg::ADDR_FFIX4:    ffix_q[3] <= pwdata[FW-1:0];
            dti_pkg::ADDR_IRQ_MASK: imask_q   <= pwdata[EN-1:0];
            default: begin
            end
         endcase
      end
   end

   // ==========================================================
   // control channel
   logic term;

   // override forces terminal control over the fieldbus
   assign term = (chan_q == dti_pkg::CHAN_TERMINAL)
               | pin_q.manual_override_input;

   // ==========================================================
   // run decode
   logic start_d;
   logic ccw_d;
   logic ilock_d;
   logic fault_d;
   logic run_d;
   logic di1;
   logic di2;

   assign di1 = pin_q.digital_input_one;
   assign di2 = pin_q.digital_input_two;

   always_comb begin
      start_d = 1'b0;
      ccw_d   = 1'b0;
      ilock_d = 1'b0;
      fault_d = 1'b0;
      if (term) begin
         fault_d = ~pin_q.digital_input_three;
         if (mode_q == dti_pkg::MODE_START_DIR) begin
            start_d = di1;
            ccw_d   = di2;
         end else begin
            start_d = di1 ^ di2;
            ccw_d   = di2 & ~di1;
            ilock_d = di1 & di2;
         end
      end else begin
         start_d = fbus_cmd.run;
         ccw_d   = fbus_cmd.ccw;
      end
      // permit must be joined by a start command
      run_d = pin_q.run_permit_input & start_d
            & ~fault_d & ~ilock_d;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         drive_run   <= 1'b0;
         drive_ccw   <= 1'b0;
         drive_coast <= 1'b1;
         fault_q     <= 1'b0;
         ilock_q     <= 1'b0;
      end else begin
         drive_run   <= run_d;
         if (run_d) begin
            drive_ccw <= ccw_d;
         end
         // permit removal lets the motor run out freely
         drive_coast <= ~pin_q.run_permit_input
                      | fault_d | ilock_d;
         fault_q     <= fault_d;
         ilock_q     <= ilock_d;
      end
   end

   // ==========================================================
   // setpoint
   logic [FW-1:0]    span;
   logic [FW+AW-1:0] prod;
   logic [FW-1:0]    aset;
   logic [1:0]       fsel;
   logic [FW-1:0]    updn_q;
   logic [31:0]      step_cnt_q;
   logic             step;
   logic [FW-1:0]    freq_d;

   assign span = (fmax_q > fmin_q) ? FW'(fmax_q - fmin_q) : '0;
   assign prod = (FW+AW)'(span) * (FW+AW)'(analog_ref);
   assign aset = FW'(fmin_q + FW'(prod >> AW));
   assign fsel = {pin_q.fix_sel_bit1, pin_q.fix_sel_bit0};
   assign step = (step_cnt_q == 32'(UPDN_STEP_CYC - 1));

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         step_cnt_q <= 32'h0000_0000;
      end else if (step) begin
         step_cnt_q <= 32'h0000_0000;
      end else begin
         step_cnt_q <= step_cnt_q + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         updn_q <= dti_pkg::FMIN_RST;
      end else if (updn_q < fmin_q) begin
         updn_q <= fmin_q;
      end else if (updn_q > fmax_q) begin
         updn_q <= fmax_q;
      end else if (step && term) begin
         if (pin_q.freq_up_input && !pin_q.freq_down_input
             && updn_q < fmax_q) begin
            updn_q <= updn_q + FW'(1);
         end else if (pin_q.freq_down_input && !pin_q.freq_up_input
                      && updn_q > fmin_q) begin
            updn_q <= updn_q - FW'(1);
         end
      end
   end

   always_comb begin
      if (!term) begin
         freq_d = fbus_freq;
      end else begin
         case (ref_q)
            dti_pkg::REF_FIXED:  freq_d = ffix_q[fsel];
            dti_pkg::REF_UPDOWN: freq_d = updn_q;
            default: begin
               // fixed one select overrides the analog word
               freq_d = pin_q.fixed_freq_one ? ffix_q[0]
                                             : aset;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         drive_freq <= '0;
      end else begin
         drive_freq <= freq_d;
      end
   end

   // ==========================================================
   // interrupts
   assign ev[dti_pkg::EV_FAULT]     = fault_d & ~fault_q;
   assign ev[dti_pkg::EV_INTERLOCK] = ilock_d & ~ilock_q;
   assign ev[dti_pkg::EV_RUN_START] = run_d & ~drive_run;
   assign ev[dti_pkg::EV_RUN_STOP]  = ~run_d & drive_run;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         istat_q <= '0;
         irq     <= 1'b0;
      end else begin
         // a new event wins over a same-cycle clear
         if (wr && paddr == dti_pkg::ADDR_IRQ_STAT) begin
            istat_q <= (istat_q & ~pwdata[EN-1:0]) | ev;
         end else begin
            istat_q <= istat_q | ev;
         end
         irq <= |(istat_q & imask_q);
      end
   end

endmodule : dti_decoder

//--- dti_chk_assertions.sv
module dti_chk (
   // clock and reset
   input wire logic               clk,
   input wire logic               rst_b,
   // apb
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pready,
   input wire logic               pslverr,
   // terminals and drive
   input wire dti_pkg::dti_pins_t pins,
   input wire logic               drive_run,
   input wire logic               drive_ccw,
   input wire logic               drive_coast,
   input wire logic               irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // =======================================================
   // apb handshake
   a_ready_once: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_wait: assert property
      (psel && !penable ##1 psel && penable |=> pready)
      else $error("pready not one cycle after access");
   a_ready_cause: assert property
      (pready |-> $past(psel) && $past(penable))
      else $error("pready without access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside pready");

   // =======================================================
   // drive command
   a_coast_idle: assert property (drive_coast |-> !drive_run)
      else $error("runs while coasting");
   a_permit_coast: assert property
      (!$past(pins.run_permit_input, 4) |-> drive_coast && !drive_run)
      else $error("no coast without permit");
   a_fault_stop: assert property
      ($past(pins.manual_override_input, 4)
       && !$past(pins.digital_input_three, 4) |-> !drive_run)
      else $error("runs with fault input low");
   a_no_start: assert property
      ($past(pins.manual_override_input, 4)
       && !$past(pins.digital_input_one, 4)
       && !$past(pins.digital_input_two, 4) |-> !drive_run)
      else $error("runs without start");
   a_dir_hold: assert property
      (!drive_run && !$past(drive_run) |-> $stable(drive_ccw))
      else $error("direction moved while stopped");

   c_error: cover property (pready && pslverr);
   c_start: cover property ($rose(drive_run));
   c_irq: cover property ($rose(irq));
endmodule : dti_chk

bind dti_decoder dti_chk u_chk (.clk, .rst_b, .psel, .penable, .pready,
   .pslverr, .pins, .drive_run, .drive_ccw, .drive_coast, .irq);

//--- dti_field.sv
module dti_field (
   // clock
   input  wire logic               clk,
   // switch settings and wiring
   input  wire dti_pkg::dti_pins_t sw,
   output dti_pkg::dti_pins_t      pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // contacts settle just after an edge
   always_ff @(posedge clk) begin
      pins <= sw;
   end
endmodule : dti_field

//--- drive_terminal_input_decoder_bench.sv
module drive_terminal_input_decoder_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk = 1'b0;
   logic               rst_b = 1'b0;
   logic               psel = 1'b0;
   logic               penable = 1'b0;
   logic               pwrite = 1'b0;
   logic [7:0]         paddr = 8'h00;
   logic [31:0]        pwdata = 32'h0;
   logic               pready;
   logic [31:0]        prdata;
   logic               pslverr;
   dti_pkg::dti_pins_t sw = '0;
   dti_pkg::dti_pins_t pins;
   dti_pkg::dti_fbus_t fbus_cmd = '0;
   logic [15:0]        fbus_freq = 16'h0123;
   logic [11:0]        aref = 12'h800;
   logic               run;
   logic               ccw;
   logic               coast;
   logic [15:0]        freq;
   logic               irq;
   logic [31:0]        rdata;
   logic               rerr;
   int                 bad_count = 0;
   int                 n_checks = 0;
   logic [31:0]        rv [7] = '{32'h0, 32'h0, 32'h1F4, 32'hC8,
                                  32'h12C, 32'h190, 32'h1F4};
   logic [9:0]         fs [4] = '{10'h082, 10'h0A2, 10'h092, 10'h0B2};

   initial begin
      forever #2.5 clk = ~clk;
   end

   dti_field u_field (.clk(clk), .sw(sw), .pins(pins));

   dti_decoder #(.UPDN_STEP_CYC(8)) DUT (.clk(clk), .rst_b(rst_b),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pins(pins), .analog_ref(aref),
      .fbus_cmd(fbus_cmd), .fbus_freq(fbus_freq), .drive_run(run),
      .drive_ccw(ccw), .drive_coast(coast), .drive_freq(freq),
      .irq(irq));

   // =======================================================
   // tasks
   task automatic tally_and_finish;
      if (bad_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic dchk(input logic [2:0] exp);
      chk({29'h0, run, ccw, coast}, {29'h0, exp});
   endtask : dchk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         tally_and_finish();
      end else begin
         rdata = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic ee);
      apb(1'b0, a, 32'h0);
      chk(rdata, e);
      chk({31'h0, rerr}, {31'h0, ee});
   endtask : rd

   task automatic pin(input logic [9:0] v, input int n);
      @(posedge clk);
      sw <= v;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : pin

   // =======================================================
   // sequence
   initial begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         rd(8'(4 * i), rv[i], 1'b0);
      end
      pin(10'h082, 8);
      chk({16'h0, freq}, 32'hFA);
      pin(10'h0C2, 8);
      chk({16'h0, freq}, 32'hC8);
      apb(1'b1, dti_pkg::ADDR_IRQ_STAT, 32'hF);
      apb(1'b1, dti_pkg::ADDR_IRQ_MASK, 32'h4);
      pin(10'h282, 8);
      dchk(3'b100);
      chk({31'h0, irq}, 32'h1);
      rd(dti_pkg::ADDR_IRQ_STAT, 32'h4, 1'b0);
      apb(1'b1, dti_pkg::ADDR_IRQ_STAT, 32'h4);
      repeat (3) @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      pin(10'h382, 8);
      dchk(3'b001);
      pin(10'h182, 8);
      dchk(3'b110);
      pin(10'h102, 8);
      dchk(3'b011);
      pin(10'h180, 8);
      dchk(3'b011);
      pin(10'h082, 8);
      dchk(3'b010);
      apb(1'b1, dti_pkg::ADDR_CTRL, 32'h100);
      for (int i = 0; i < 4; i++) begin
         pin(fs[i], 8);
         chk({16'h0, freq}, rv[i + 3]);
      end
      apb(1'b1, dti_pkg::ADDR_FMIN, 32'h8);
      apb(1'b1, dti_pkg::ADDR_FMAX, 32'h10);
      apb(1'b1, dti_pkg::ADDR_CTRL, 32'h200);
      pin(10'h08A, 400);
      chk({16'h0, freq}, 32'h10);
      pin(10'h086, 400);
      chk({16'h0, freq}, 32'h8);
      apb(1'b1, dti_pkg::ADDR_CTRL, 32'h10);
      aref <= 12'hFFF;
      pin(10'h382, 8);
      dchk(3'b110);
      chk({16'h0, freq}, 32'hF);
      pin(10'h282, 8);
      dchk(3'b100);
      pin(10'h182, 8);
      dchk(3'b000);
      apb(1'b1, dti_pkg::ADDR_CTRL, 32'h1);
      @(posedge clk);
      fbus_cmd <= 2'b11;
      pin(10'h082, 8);
      dchk(3'b110);
      chk({16'h0, freq}, 32'h123);
      pin(10'h083, 8);
      dchk(3'b010);
      pin(10'h203, 8);
      dchk(3'b011);
      rd(8'h28, 32'h0, 1'b1);
      tally_and_finish();
   end
endmodule : drive_terminal_input_decoder_bench
